// >>> core/seq_pkg.sv
package seq_pkg;
    localparam int ADDR_W = 24;
    localparam int HALF_W = 12;
    localparam int BUS_W = 7;
    localparam int SEL_W = 5;
    localparam int DELAY_MAX = 7;
    localparam int FIFO_DEPTH = 2;
    localparam int PIN_W = 14;
    // reset sequence: internal init length, busy flag span
    localparam logic [4:0] INIT_CYCLES = 5'h1a;
    localparam logic [4:0] BUSY_CYCLES = 5'h19;
    // host address that launches a sequence
    localparam logic [6:0] START_CMD_ADDR = 7'h7f;
    localparam logic [23:0] ADDR_ZERO = 24'h00_0000;
    localparam logic [23:0] COUNT_ONE = 24'h00_0001;

    typedef enum logic [1:0] {
        MODE_ONESHOT = 2'b00,
        MODE_RESTART = 2'b01,
        MODE_CONT = 2'b10
    } mode_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_HOLD = 2'b10,
        ST_STOP = 2'b11
    } gen_state_type;

    typedef struct packed {
        logic [23:0] start_address;
        logic [23:0] address_increment;
        logic [23:0] block_size;
        logic [23:0] block_increment;
        logic [23:0] block_count;
        mode_type mode;
        logic dual;
        logic [2:0] half_delay;
    } cfg_type;

    typedef struct packed {
        logic [23:0] addr;
        logic first;
        logic block_end;
        logic seq_done;
    } word_type;

    typedef logic [23:0][4:0] xmap_type;

    function automatic xmap_type ident_map();
        xmap_type m;
        for (int i = 0; i < ADDR_W; i++) begin
            m[i] = 5'(i);
        end
        return m;
    endfunction : ident_map

    localparam xmap_type XMAP_IDENT = ident_map();

    // dual mode cuts the carry between the halves
    function automatic logic [23:0] add24(input logic [23:0] a, input logic [23:0] b,
                                          input logic dual);
        logic [12:0] lo;
        logic [11:0] hi;
        lo = {1'b0, a[11:0]} + {1'b0, b[11:0]};
        hi = a[23:12] + b[23:12] + {11'h000, lo[12] & ~dual};
        return {hi, lo[11:0]};
    endfunction : add24
endpackage : seq_pkg

// >>> core/addr_buffer.sv
`timescale 1ns/10ps
module addr_buffer #(
    parameter int WIDTH = 27,
    parameter int DEPTH = 2
) (
    input wire logic clk_sys, // system clock
    input wire logic nrst, // sync reset, low active
    input wire logic in_valid, // word offered
    output logic in_ready, // room for a word
    input wire logic [WIDTH-1:0] in_data, // word in
    output logic out_valid, // word held
    input wire logic out_ready, // receiver takes word
    output logic [WIDTH-1:0] out_data // oldest word
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
    localparam logic [PTR_W:0] CNT_FULL = (PTR_W + 1)'(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [WIDTH-1:0] mem_next [DEPTH];
    logic [PTR_W-1:0] wr_reg, wr_next, rd_reg, rd_next;
    logic [PTR_W:0] cnt_reg, cnt_next;
    logic push, pop;

    assign in_ready = (cnt_reg != CNT_FULL);
    assign out_valid = (cnt_reg != '0);
    assign out_data = mem_reg[rd_reg];

    always_comb begin
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        mem_next = mem_reg;
        wr_next = wr_reg;
        rd_next = rd_reg;
        cnt_next = cnt_reg;
        if (push) begin
            mem_next[wr_reg] = in_data;
            wr_next = (wr_reg == PTR_LAST) ? '0 : wr_reg + 1'b1;
        end
        if (pop) begin
            rd_next = (rd_reg == PTR_LAST) ? '0 : rd_reg + 1'b1;
        end
        if (push && !pop) begin
            cnt_next = cnt_reg + 1'b1;
        end else if (pop && !push) begin
            cnt_next = cnt_reg - 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end else begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
            cnt_reg <= cnt_next;
        end
        mem_reg <= mem_next;
    end
endmodule : addr_buffer

// >>> core/addr_sequencer.sv
`timescale 1ns/10ps
//
// Contract
// [RULE_01] internal reset runs 26 clocks after reset release before normal operation
// [RULE_02] reset sets crosspoint map and configuration; clock must keep running
// [RULE_03] busy output low from one clock after release for 25 clocks
// [RULE_04] host writes are ignored while busy is low
// [RULE_05] host bus captured on rising write strobe when chip select low
// [RULE_06] chip select high: nothing captured from the host bus
// [RULE_07] register select high marks an address, low marks data
// [RULE_08] two active-low enables gate upper and lower twelve address outputs
// [RULE_09] external start low pulse begins a sequence once it returns high
// [RULE_10] external party holds start low for exactly one clock
// [RULE_11] block hold at a block boundary stops generation until released
// [RULE_12] block end flag low while last address of a block shows
// [RULE_13] sequence done flag low while final address of a sequence shows
// [RULE_14] first address flag low while first address of a sequence shows
// [RULE_15] sync start output pulses only for starts not from external start
// [RULE_16] crosspoint routes any generator bit to any of 24 output bits
// [RULE_17] generator can run as two independent 12-bit sequencers
// [RULE_18] programmable delay makes upper twelve outputs lag the lower half
// [RULE_19] first address is start address; then add address increment
// [RULE_20] after block size, next is block start plus block increment
// [RULE_21] one-shot, one-shot with restart, continuous without done flag
// [RULE_22] dual mode suppresses half carry; halves offset up to 7 clocks
// [RULE_23] one new registered address per clock at most
// [RULE_24] flags registered together with the address they describe
module addr_sequencer
    import seq_pkg::*;
(
    input wire logic clk_sys, // system clock
    input wire logic nrst, // sync reset, low active
    input wire logic write_n, // host write strobe pin
    input wire logic chip_select_n, // host chip select pin
    input wire logic register_select, // 1 address, 0 data
    input wire logic [6:0] host_bus, // host data pins
    input wire logic upper_output_enable_n, // enables bits 23..12
    input wire logic lower_output_enable_n, // enables bits 11..0
    input wire logic external_start_n, // start pin
    input wire logic block_hold, // hold at block boundary
    input wire seq_pkg::cfg_type cfg, // sequence configuration
    input wire logic map_load, // load crosspoint map
    input wire seq_pkg::xmap_type map_in, // new crosspoint map
    input wire logic sink_ready, // receiver takes an address
    output logic [23:0] address_out, // address pins
    output logic [23:0] address_oe_n, // low while pin driven
    output logic block_end_flag_n, // last of block
    output logic sequence_done_n, // last of sequence
    output logic first_address_valid_n, // first of sequence
    output logic sync_start_out_n, // start for other sequencers
    output logic init_in_progress_n, // busy after reset
    output logic [6:0] host_cfg_addr, // captured register address
    output logic [6:0] host_cfg_data, // captured data
    output logic host_cfg_strobe // one-clock data write pulse
);
    import seq_pkg::*;

    // pin synchroniser
    logic [PIN_W-1:0] pin_raw, pin_s1_reg, pin_s2_reg;
    logic wr_prev_reg, st_prev_reg;
    logic wr_s, cs_s, sel_s, ext_s, hold_s, oeh_s, oel_s;
    logic [6:0] bus_s;

    assign pin_raw = {write_n, chip_select_n, register_select, host_bus,
                      external_start_n, block_hold, upper_output_enable_n,
                      lower_output_enable_n};
    assign {wr_s, cs_s, sel_s, bus_s, ext_s, hold_s, oeh_s, oel_s} = pin_s2_reg;

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            pin_s1_reg <= 14'h3fff;
            pin_s2_reg <= 14'h3fff;
            wr_prev_reg <= 1'b1;
            st_prev_reg <= 1'b1;
        end else begin
            pin_s1_reg <= pin_raw;
            pin_s2_reg <= pin_s1_reg;
            wr_prev_reg <= wr_s;
            st_prev_reg <= ext_s;
        end
    end

    // reset sequence and host port
    logic [4:0] init_reg, init_next;
    logic busy_next, ready;
    logic wr_rise, soft_start, ext_launch;
    logic [6:0] haddr_next, hdata_next;
    logic hstb_next;

    always_comb begin
        init_next = (init_reg == INIT_CYCLES) ? init_reg : init_reg + 1'b1; // [RULE_01]
        busy_next = !((init_next != 5'h00) && (init_next <= BUSY_CYCLES)); // [RULE_03]
        ready = (init_reg == INIT_CYCLES);
        wr_rise = wr_s && !wr_prev_reg && !cs_s && ready; // [RULE_04] [RULE_05] [RULE_06]
        ext_launch = ext_s && !st_prev_reg; // [RULE_09]
        haddr_next = host_cfg_addr;
        hdata_next = host_cfg_data;
        hstb_next = 1'b0;
        soft_start = 1'b0;
        if (wr_rise && sel_s) begin
            haddr_next = bus_s; // [RULE_07]
            soft_start = (bus_s == START_CMD_ADDR);
        end else if (wr_rise) begin
            hdata_next = bus_s; // [RULE_07]
            hstb_next = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            init_reg <= 5'h00;
            init_in_progress_n <= 1'b1;
            host_cfg_addr <= 7'h00;
            host_cfg_data <= 7'h00;
            host_cfg_strobe <= 1'b0;
        end else begin
            init_reg <= init_next;
            init_in_progress_n <= busy_next;
            host_cfg_addr <= haddr_next;
            host_cfg_data <= hdata_next;
            host_cfg_strobe <= hstb_next;
        end
    end

    // address generator
    gen_state_type state_reg, state_next;
    logic [23:0] addr_reg, addr_next, bstart_reg, bstart_next;
    logic [23:0] inblk_reg, inblk_next, blknum_reg, blknum_next;
    logic first_reg, first_next, restart_reg, restart_next, sync_next;
    logic last_in_blk, seq_end, do_block, do_restart, launch;
    logic gen_valid, gen_ready;
    word_type gen_word;

    always_comb begin
        state_next = state_reg;
        addr_next = addr_reg;
        bstart_next = bstart_reg;
        inblk_next = inblk_reg;
        blknum_next = blknum_reg;
        first_next = first_reg;
        restart_next = restart_reg;
        do_block = 1'b0;
        do_restart = 1'b0;
        last_in_blk = (inblk_reg >= cfg.block_size);
        seq_end = last_in_blk && (blknum_reg >= cfg.block_count)
                  && (cfg.mode != MODE_CONT); // [RULE_21]
        gen_word = '{addr: addr_reg, first: first_reg, block_end: last_in_blk,
                     seq_done: seq_end}; // [RULE_24]
        gen_valid = (state_reg == ST_RUN);
        if (gen_valid && gen_ready) begin // [RULE_23]
            first_next = 1'b0;
            if (!last_in_blk) begin
                addr_next = add24(addr_reg, cfg.address_increment, cfg.dual); // [RULE_19] [RULE_17]
                inblk_next = inblk_reg + COUNT_ONE;
            end else if (seq_end && cfg.mode == MODE_ONESHOT) begin
                state_next = ST_STOP; // [RULE_21]
            end else if (hold_s) begin
                state_next = ST_HOLD; // [RULE_11]
                restart_next = seq_end;
            end else begin
                do_restart = seq_end; // [RULE_21]
                do_block = !seq_end;
            end
        end else if (state_reg == ST_HOLD && !hold_s) begin
            state_next = ST_RUN;
            do_restart = restart_reg;
            do_block = !restart_reg;
        end
        if (do_block) begin
            addr_next = add24(bstart_reg, cfg.block_increment, cfg.dual); // [RULE_20]
            bstart_next = addr_next;
            inblk_next = COUNT_ONE;
            blknum_next = blknum_reg + COUNT_ONE;
        end
        launch = do_restart || ((soft_start || ext_launch) && ready); // [RULE_01]
        sync_next = !(do_restart || (soft_start && ready)); // [RULE_15]
        if (launch) begin
            addr_next = add24(cfg.start_address, ADDR_ZERO, cfg.dual); // [RULE_19]
            bstart_next = addr_next;
            inblk_next = COUNT_ONE;
            blknum_next = COUNT_ONE;
            first_next = 1'b1; // [RULE_14]
            state_next = ST_RUN;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            state_reg <= ST_IDLE;
            addr_reg <= ADDR_ZERO;
            bstart_reg <= ADDR_ZERO;
            inblk_reg <= COUNT_ONE;
            blknum_reg <= COUNT_ONE;
            first_reg <= 1'b0;
            restart_reg <= 1'b0;
            sync_start_out_n <= 1'b1;
        end else begin
            state_reg <= state_next;
            addr_reg <= addr_next;
            bstart_reg <= bstart_next;
            inblk_reg <= inblk_next;
            blknum_reg <= blknum_next;
            first_reg <= first_next;
            restart_reg <= restart_next;
            sync_start_out_n <= sync_next;
        end
    end

    // buffer, crosspoint, half delay, output pins
    logic buf_valid, pop;
    word_type buf_word, word_reg, word_next;
    logic [23:0] mapped;
    xmap_type xmap_reg, xmap_next;
    logic [6:0][11:0] dly_reg, dly_next;
    logic [11:0] upper_now, upper_reg, upper_next;

    addr_buffer #(
        .WIDTH($bits(word_type)),
        .DEPTH(FIFO_DEPTH)
    ) u_buffer (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .in_valid(gen_valid),
        .in_ready(gen_ready),
        .in_data(gen_word),
        .out_valid(buf_valid),
        .out_ready(sink_ready),
        .out_data(buf_word)
    );

    generate
        for (genvar gi = 0; gi < ADDR_W; gi++) begin : g_xpoint
            assign mapped[gi] = (xmap_reg[gi] < 5'h18) ?
                                buf_word.addr[xmap_reg[gi]] : 1'b0; // [RULE_16]
        end
    endgenerate

    always_comb begin
        pop = buf_valid && sink_ready;
        xmap_next = (map_load && ready) ? map_in : xmap_reg; // [RULE_04]
        word_next = word_reg;
        if (pop) begin
            word_next = buf_word;
            word_next.addr = mapped;
        end
        upper_now = word_next.addr[23:12];
        dly_next = {dly_reg[5:0], upper_now};
        upper_next = (cfg.half_delay == 3'h0) ? upper_now
                     : dly_reg[cfg.half_delay - 3'h1]; // [RULE_18] [RULE_22]
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            xmap_reg <= XMAP_IDENT; // [RULE_02]
            word_reg <= '0;
            dly_reg <= '0;
            upper_reg <= 12'h000;
            address_oe_n <= 24'hff_ffff;
        end else begin
            xmap_reg <= xmap_next;
            word_reg <= word_next;
            dly_reg <= dly_next;
            upper_reg <= upper_next;
            address_oe_n <= {{HALF_W{oeh_s}}, {HALF_W{oel_s}}}; // [RULE_08]
        end
    end

    assign address_out = {upper_reg, word_reg.addr[11:0]};
    assign block_end_flag_n = !word_reg.block_end; // [RULE_12]
    assign sequence_done_n = !word_reg.seq_done; // [RULE_13]
    assign first_address_valid_n = !word_reg.first; // [RULE_14]

    // checks
    logic [5:0] busy_len_reg;
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            busy_len_reg <= 6'h00;
        end else if (!init_in_progress_n) begin
            busy_len_reg <= busy_len_reg + 6'h01;
        end
    end

    AST_BUSY_LEN: assert property (@(posedge clk_sys) disable iff (!nrst) // [RULE_03]
        $rose(init_in_progress_n) |-> busy_len_reg == 6'h19)
        else $error("busy span not 25 clocks");
    AST_BUSY_START: assert property (@(posedge clk_sys) // [RULE_03]
        $rose(nrst) |=> !init_in_progress_n && busy_len_reg == 6'h00)
        else $error("busy not low one clock after release");
    AST_IDLE_INIT: assert property (@(posedge clk_sys) disable iff (!nrst) // [RULE_01]
        (state_reg != ST_IDLE) |-> init_reg == INIT_CYCLES)
        else $error("sequencer left idle during init");
    AST_NO_BUSY_WRITE: assert property (@(posedge clk_sys) disable iff (!nrst) // [RULE_04]
        (wr_s && !wr_prev_reg && !init_in_progress_n) |=> !host_cfg_strobe)
        else $error("write taken while busy");
    AST_CAPTURE: assert property (@(posedge clk_sys) disable iff (!nrst) // [RULE_05]
        (wr_s && !wr_prev_reg && !cs_s && !sel_s && ready)
        |=> host_cfg_strobe && host_cfg_data == $past(bus_s))
        else $error("data write not captured");
    AST_CS_HIGH: assert property (@(posedge clk_sys) disable iff (!nrst) // [RULE_06]
        (wr_s && !wr_prev_reg && cs_s) |=> !host_cfg_strobe && $stable(host_cfg_addr))
        else $error("write taken without chip select");
    AST_STEP: assert property (@(posedge clk_sys) disable iff (!nrst) // [RULE_19]
        (gen_valid && gen_ready && !last_in_blk && !launch)
        |=> addr_reg == add24($past(addr_reg), $past(cfg.address_increment), $past(cfg.dual)))
        else $error("address step wrong");
    AST_BLOCK: assert property (@(posedge clk_sys) disable iff (!nrst) // [RULE_20]
        (do_block && !launch)
        |=> addr_reg == add24($past(bstart_reg), $past(cfg.block_increment), $past(cfg.dual))
            && bstart_reg == addr_reg)
        else $error("block start wrong");
    AST_HOLD: assert property (@(posedge clk_sys) disable iff (!nrst) // [RULE_11]
        (state_reg == ST_HOLD && hold_s && !soft_start && !ext_launch) |=> !gen_valid)
        else $error("generation ran during hold");
    AST_CONT: assert property (@(posedge clk_sys) disable iff (!nrst) // [RULE_21]
        (cfg.mode == MODE_CONT && gen_valid) |-> !gen_word.seq_done)
        else $error("done raised in continuous mode");
    AST_EXT_NOSYNC: assert property (@(posedge clk_sys) disable iff (!nrst) // [RULE_15]
        (ext_launch && !soft_start && !do_restart) |=> sync_start_out_n)
        else $error("sync start pulsed for external start");
    AST_FLAGS: assert property (@(posedge clk_sys) disable iff (!nrst) // [RULE_24]
        pop |=> block_end_flag_n == !$past(buf_word.block_end)
            && first_address_valid_n == !$past(buf_word.first))
        else $error("flags not with their address");
endmodule : addr_sequencer

// >>> testbench/seq_sink_model.sv
`timescale 1ns/10ps
module seq_sink_model
    import seq_pkg::*;
(
    input wire logic clk_sys, // system clock
    input wire logic nrst, // sync reset, low active
    input wire logic stall_en, // allow random stalls
    output logic sink_ready, // takes an address
    input wire logic [23:0] address_out, // address pins
    input wire logic block_end_flag_n, // last of block
    input wire logic sequence_done_n, // last of sequence
    input wire logic first_address_valid_n // first of sequence
);
    word_type got[$];
    word_type prev;
    word_type cur;

    assign cur = '{address_out, ~first_address_valid_n, ~block_end_flag_n, ~sequence_done_n};

    initial sink_ready = 1'b1;

    // stalls come at random so the buffer in front must hold words
    always @(negedge clk_sys) begin
        sink_ready <= stall_en ? ($urandom % 3 != 0) : 1'b1;
    end

    // a new word shows as a change of address or flags
    always @(posedge clk_sys) begin
        if (!nrst) begin
            prev <= cur;
        end else if (cur !== prev) begin
            got.push_back(cur);
            prev <= cur;
        end
    end
endmodule : seq_sink_model

// >>> testbench/block_address_sequencer_ports_tb_top.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin \
    cmp_count++; \
    if ((g) !== (e)) begin \
        n_mismatch++; \
        $display("wrong value %s expected %h seen %h", nm, e, g); \
    end \
end
module block_address_sequencer_ports_tb_top;
    import seq_pkg::*;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic write_n = 1'b1;
    logic chip_select_n = 1'b1;
    logic register_select = 1'b0;
    logic [6:0] host_bus = 7'h00;
    logic upper_output_enable_n = 1'b1;
    logic lower_output_enable_n = 1'b1;
    logic external_start_n = 1'b1;
    logic block_hold = 1'b0;
    cfg_type cfg = '0;
    logic map_load = 1'b0;
    xmap_type map_in = XMAP_IDENT;
    logic stall_en = 1'b0;
    logic sink_ready;
    logic [23:0] address_out;
    logic [23:0] address_oe_n;
    logic block_end_flag_n, sequence_done_n, first_address_valid_n;
    logic sync_start_out_n, init_in_progress_n, host_cfg_strobe;
    logic [6:0] host_cfg_addr;
    logic [6:0] host_cfg_data;
    int n_mismatch = 0;
    int cmp_count = 0;
    int n_strobe = 0;
    int n_sync = 0;
    int init_cnt = 0;
    int cyc = 0;
    int rel = 0;
    int seed, n;
    word_type exp_q[$];
    xmap_type cur_map = XMAP_IDENT;

    always #5 clk_sys = ~clk_sys;

    addr_sequencer u_dut (.clk_sys(clk_sys), .nrst(nrst), .write_n(write_n),
        .chip_select_n(chip_select_n), .register_select(register_select),
        .host_bus(host_bus), .upper_output_enable_n(upper_output_enable_n),
        .lower_output_enable_n(lower_output_enable_n), .external_start_n(external_start_n),
        .block_hold(block_hold), .cfg(cfg), .map_load(map_load), .map_in(map_in),
        .sink_ready(sink_ready), .address_out(address_out), .address_oe_n(address_oe_n),
        .block_end_flag_n(block_end_flag_n), .sequence_done_n(sequence_done_n),
        .first_address_valid_n(first_address_valid_n), .sync_start_out_n(sync_start_out_n),
        .init_in_progress_n(init_in_progress_n), .host_cfg_addr(host_cfg_addr),
        .host_cfg_data(host_cfg_data), .host_cfg_strobe(host_cfg_strobe));

    seq_sink_model u_sink (.clk_sys(clk_sys), .nrst(nrst), .stall_en(stall_en),
        .sink_ready(sink_ready), .address_out(address_out),
        .block_end_flag_n(block_end_flag_n), .sequence_done_n(sequence_done_n),
        .first_address_valid_n(first_address_valid_n));

    always @(posedge clk_sys) begin
        cyc++;
        if (host_cfg_strobe === 1'b1) n_strobe++;
        if (sync_start_out_n === 1'b0) n_sync++;
        if (nrst === 1'b0) init_cnt = 0;
        else if (init_in_progress_n === 1'b0) init_cnt++;
    end

    function automatic logic [23:0] add_h(input logic [23:0] a, b, input logic dual);
        return dual ? {12'(a[23:12] + b[23:12]), 12'(a[11:0] + b[11:0])} : 24'(a + b);
    endfunction : add_h

    function automatic logic [23:0] xmap(input logic [23:0] a, input xmap_type m);
        logic [23:0] r;
        for (int i = 0; i < 24; i++) begin
            r[i] = (m[i] < 24) ? a[m[i]] : 1'b0;
        end
        return r;
    endfunction : xmap

    task automatic gen(input int cnt);
        int bs, nb, i, b;
        logic [23:0] a, bst;
        word_type w;
        bs = (cfg.block_size == 0) ? 1 : int'(cfg.block_size);
        nb = (cfg.block_count == 0) ? 1 : int'(cfg.block_count);
        i = 0;
        b = 0;
        a = cfg.start_address;
        bst = a;
        for (int k = 0; k < cnt; k++) begin
            w.addr = xmap(a, cur_map);
            w.first = (i == 0 && b == 0);
            w.block_end = (i == bs - 1);
            w.seq_done = w.block_end && b == nb - 1 && cfg.mode != MODE_CONT;
            exp_q.push_back(w);
            i++;
            a = add_h(a, cfg.address_increment, cfg.dual);
            if (i == bs) begin
                i = 0;
                b++;
                bst = add_h(bst, cfg.block_increment, cfg.dual);
                a = bst;
            end
            if (w.seq_done && cfg.mode == MODE_RESTART) begin
                b = 0;
                a = cfg.start_address;
                bst = a;
            end
        end
    endtask : gen

    task automatic tick(input int k);
        repeat (k) @(negedge clk_sys);
    endtask : tick

    task automatic host_write(input logic cs, input logic sel, input logic [6:0] v);
        chip_select_n = cs;
        register_select = sel;
        host_bus = v;
        write_n = 1'b0;
        tick(4);
        write_n = 1'b1;
        tick(4);
        chip_select_n = 1'b1;
    endtask : host_write

    task automatic wait_ready();
        int g;
        g = 0;
        tick(1);
        while (init_in_progress_n !== 1'b1 && g < 100) begin
            tick(1);
            g++;
        end
        `CHK("ready_edge", 26, cyc - rel)
        `CHK("busy_len", 25, init_cnt)
        tick(2);
    endtask : wait_ready

    task automatic do_reset();
        nrst = 1'b0;
        tick(20);
        `CHK("oe_in_reset", 24'hff_ffff, address_oe_n)
        rel = cyc;
        nrst = 1'b1;
    endtask : do_reset

    task automatic ext_start();
        external_start_n = 1'b0;
        tick(1);
        external_start_n = 1'b1;
    endtask : ext_start

    task automatic collect(input int cnt);
        int g;
        g = 0;
        while (u_sink.got.size() < cnt && g < 3000) begin
            tick(1);
            g++;
        end
        for (int k = 0; k < cnt; k++) begin
            `CHK("word", exp_q[k], u_sink.got[k])
        end
    endtask : collect

    task automatic summarize();
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize

    initial begin
        #200_000;
        n_mismatch++;
        summarize();
    end

    initial begin
        seed = $urandom(79166);
        tick(1);
        do_reset();
        tick(1);
        host_write(1'b0, 1'b1, 7'h2a);
        wait_ready();
        `CHK("busy_strobe", 0, n_strobe)
        `CHK("busy_addr", 7'h00, host_cfg_addr)
        host_write(1'b1, 1'b0, 7'h33);
        `CHK("cs_high_strobe", 0, n_strobe)
        host_write(1'b0, 1'b1, 7'h15);
        host_write(1'b0, 1'b0, 7'h4c);
        tick(4);
        `CHK("cfg_addr", 7'h15, host_cfg_addr)
        `CHK("cfg_data", 7'h4c, host_cfg_data)
        `CHK("strobes", 1, n_strobe)
        for (int j = 0; j < 4; j++) begin
            {upper_output_enable_n, lower_output_enable_n} = 2'(j);
            tick(5);
            `CHK("oe", {{12{j[1]}}, {12{j[0]}}}, address_oe_n)
        end
        {upper_output_enable_n, lower_output_enable_n} = 2'b00;
        cfg.start_address = 24'($urandom);
        cfg.address_increment = 24'($urandom) | 24'h00_0001;
        cfg.block_size = 24'(1 + $urandom % 4);
        cfg.block_count = 24'(1 + $urandom % 3);
        cfg.block_increment = 24'($urandom);
        cfg.mode = MODE_ONESHOT;
        n = int'(cfg.block_size) * int'(cfg.block_count);
        stall_en = 1'b1;
        u_sink.got.delete();
        n_sync = 0;
        ext_start();
        gen(n);
        collect(n);
        tick(30);
        `CHK("oneshot_holds", n, u_sink.got.size())
        `CHK("ext_no_sync", 0, n_sync)
        for (int j = 0; j < 24; j++) begin
            map_in[j] = 5'(23 - j);
        end
        map_load = 1'b1;
        tick(1);
        map_load = 1'b0;
        cur_map = map_in;
        cfg.mode = MODE_RESTART;
        stall_en = 1'b0;
        tick(4);
        u_sink.got.delete();
        exp_q.delete();
        n_sync = 0;
        host_write(1'b0, 1'b1, START_CMD_ADDR);
        gen(2 * n);
        collect(2 * n);
        tick(3);
        `CHK("sync_pulses", 1'b1, n_sync >= 2)
        map_in = XMAP_IDENT;
        cur_map = XMAP_IDENT;
        do_reset();
        wait_ready();
        cfg.start_address = 24'h00a_ffe;
        cfg.address_increment = 24'h001_001;
        cfg.block_size = 24'h00_0005;
        cfg.block_count = 24'h00_0001;
        cfg.block_increment = 24'h010_010;
        cfg.mode = MODE_CONT;
        cfg.dual = 1'b1;
        u_sink.got.delete();
        exp_q.delete();
        block_hold = 1'b1;
        ext_start();
        gen(12);
        tick(30);
        `CHK("hold_stops", 5, u_sink.got.size())
        block_hold = 1'b0;
        collect(12);
        summarize();
    end
endmodule : block_address_sequencer_ports_tb_top
